/* File: logic/hv_output_boost_control.sv */
// serial loader, line latches and boost control state machine
`timescale 1ns/10ps
module hv_output_boost_control #(
  parameter bit HAS_BOOST = 1'b1,
  parameter int SOFT_CYCLES = hv_boost_pkg::SOFT_START_OSC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic latch_strobe,
  input wire logic out_gate,
  input wire logic switch_drive_input,
  input wire logic rail_at_target,
  input wire logic current_at_limit,
  output logic [hv_boost_pkg::LINES-1:0] hv_lines,
  output logic [hv_boost_pkg::WORD_W-1:0] mask_word,
  output hv_boost_pkg::cfg_s cfg_word,
  output logic [1:0] active_limit_code,
  output logic switch_gate,
  output logic discharge_en,
  output logic soft_start_active
);
  import hv_boost_pkg::*;

  localparam int CNT_W = $clog2(SOFT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SOFT_CYCLES - 1);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // every pin passes two flops; a third stage gives edge detection
  logic [6:0] pin_in;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] sync3_q;
  assign pin_in = {current_at_limit, rail_at_target, switch_drive_input,
                   out_gate, latch_strobe, sdin, sclk};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 7'h04; // strobe idles high: no false edge after reset
      sync2_q <= 7'h04;
      sync3_q <= 7'h04;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic sclk_fall;
  logic din_s;
  logic stb_s;
  logic stb_rise;
  logic stb_fall;
  logic oe_s;
  logic osc_s;
  logic osc_rise;
  logic at_target_s;
  logic at_limit_s;
  assign sclk_fall = sync3_q[0] & ~sync2_q[0];
  assign din_s = sync2_q[1];
  assign stb_s = sync2_q[2];
  assign stb_rise = sync2_q[2] & ~sync3_q[2];
  assign stb_fall = ~sync2_q[2] & sync3_q[2];
  assign oe_s = sync2_q[3];
  assign osc_s = sync2_q[4];
  assign osc_rise = sync2_q[4] & ~sync3_q[4];
  assign at_target_s = sync2_q[5];
  assign at_limit_s = sync2_q[6];

  // ----------------------------------------------------------------------
  // shift register and latches
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [LINES-1:0] mask_q, mask_d;
  cfg_s cfg_q, cfg_d;

  // falling-edge sampling keeps data stable; the host moves it while high
  always_comb begin
    shift_d = shift_q;
    mask_d = mask_q;
    cfg_d = cfg_q;
    if (stb_fall) begin
      shift_d = WORD_RESET;
    end else if (!stb_s && sclk_fall) begin
      shift_d = {shift_q[WORD_W-2:0], din_s};
    end
    if (stb_rise) begin
      if (shift_q[SEL_BIT]) begin
        mask_d = shift_q[MASK_LSB +: LINES];
      end else begin
        cfg_d = cfg_s'(shift_q[LIMIT_OFF_BIT:LEVEL_LSB]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= WORD_RESET;
      mask_q <= MASK_RESET;
      cfg_q <= CFG_RESET;
    end else begin
      shift_q <= shift_d;
      mask_q <= mask_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------------
  // line drivers
  // ----------------------------------------------------------------------
  logic [LINES-1:0] lines_q, lines_d;
  logic [WORD_W-1:0] word_q, word_d;

  // the gate pin cycles lines without reloading the mask
  always_comb begin
    lines_d = oe_s ? mask_q : MASK_RESET;
    // top lines dead on boost part
    if (HAS_BOOST) begin
      lines_d[LINES-1:LINES-2] = 2'h0;
    end
    word_d = {2'h0, mask_q, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lines_q <= MASK_RESET;
      word_q <= WORD_RESET;
    end else begin
      lines_q <= lines_d;
      word_q <= word_d;
    end
  end

  // ----------------------------------------------------------------------
  // soft start
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SS_IDLE, SS_RUN, SS_DONE} ss_e;
  ss_e ss_q, ss_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] prev_level_q;
  logic enabled;
  logic start_evt;
  logic [1:0] limit_q, limit_d;
  logic ss_run_q, ss_run_d;
  assign enabled = cfg_q.boost_level_code != LEVEL_OFF;
  assign start_evt = enabled && prev_level_q == LEVEL_OFF;

  // counts switching-input cycles, not clk, so the interval tracks the pwm
  always_comb begin
    ss_d = ss_q;
    cnt_d = cnt_q;
    case (ss_q)
      SS_IDLE: begin
        ss_d = SS_IDLE;
      end
      SS_RUN: begin
        if (osc_rise) begin
          if (cnt_q == CNT_LAST) begin
            ss_d = SS_DONE;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      SS_DONE: begin
        ss_d = SS_DONE;
      end
      default: begin
        ss_d = SS_IDLE;
      end
    endcase
    if (!enabled) begin
      ss_d = SS_IDLE;
    end
    if (start_evt) begin
      ss_d = cfg_q.soft_start_disable ? SS_DONE : SS_RUN;
      cnt_d = '0;
    end
    ss_run_d = ss_d == SS_RUN;
    if (ss_q == SS_RUN && !cfg_q.soft_start_disable) begin
      limit_d = LIMIT_SOFT;
    end else begin
      limit_d = cfg_q.current_limit_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_q <= SS_IDLE;
      cnt_q <= '0;
      limit_q <= LIMIT_SOFT;
      ss_run_q <= 1'b0;
    end else begin
      ss_q <= ss_d;
      cnt_q <= cnt_d;
      limit_q <= limit_d;
      ss_run_q <= ss_run_d;
    end
  end

  // ----------------------------------------------------------------------
  // regulation and discharge
  // ----------------------------------------------------------------------
  logic stop_q, stop_d;
  logic gate_q, gate_d;
  logic dis_q, dis_d;
  logic lowered;
  logic raised;
  assign lowered = prev_level_q != LEVEL_OFF &&
                   cfg_q.boost_level_code < prev_level_q;
  assign raised = cfg_q.boost_level_code > prev_level_q;

  always_comb begin
    // release waits for an osc rise only when sync release is set
    stop_d = stop_q;
    if (!at_target_s) begin
      stop_d = 1'b0;
    end else if (!cfg_q.sync_release || osc_rise) begin
      stop_d = 1'b1;
    end
    gate_d = osc_s && enabled && HAS_BOOST && !stop_q &&
             !(at_limit_s && !cfg_q.limit_disable);
    dis_d = dis_q;
    if (at_target_s || !enabled) begin
      dis_d = 1'b0;
    end
    if (raised) begin
      dis_d = 1'b0;
    end
    // lowering starts discharge; set beats clear
    if (lowered && enabled && HAS_BOOST) begin
      dis_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level_q <= LEVEL_OFF;
      stop_q <= 1'b0;
      gate_q <= 1'b0;
      dis_q <= 1'b0;
    end else begin
      prev_level_q <= cfg_q.boost_level_code;
      stop_q <= stop_d;
      gate_q <= gate_d;
      dis_q <= dis_d;
    end
  end

  assign hv_lines = lines_q;
  assign mask_word = word_q;
  assign cfg_word = cfg_q;
  assign active_limit_code = limit_q;
  assign switch_gate = gate_q;
  assign discharge_en = dis_q;
  assign soft_start_active = ss_run_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_cfg_select: assert property (@(posedge clk)
    disable iff (!rst_n) stb_rise && !shift_q[SEL_BIT] |=>
    cfg_q == $past(shift_q[8:1]) && mask_q == $past(mask_q))
    else $error("config word not loaded");
  a_mask_select: assert property (@(posedge clk)
    disable iff (!rst_n) stb_rise && shift_q[SEL_BIT] |=>
    mask_q == $past(shift_q[21:1]) && cfg_q == $past(cfg_q))
    else $error("mask word not loaded");
  a_top_bits_zero: assert property (@(posedge clk)
    disable iff (!rst_n) mask_word[23:22] == 2'h0)
    else $error("unimplemented bits not zero");
  a_reset_clear: assert property (@(posedge clk)
    $rose(rst_n) |-> mask_q == MASK_RESET && hv_lines == MASK_RESET)
    else $error("mask not cleared by reset");
  a_boost_lines: assert property (@(posedge clk)
    disable iff (!rst_n) HAS_BOOST |-> hv_lines[20:19] == 2'h0)
    else $error("lines 19/20 driven on boost part");
  a_gate_low: assert property (@(posedge clk)
    disable iff (!rst_n) !oe_s |=> hv_lines == MASK_RESET)
    else $error("lines not forced low");
  a_gate_follow: assert property (@(posedge clk)
    disable iff (!rst_n) oe_s |=> hv_lines[18:0] == $past(mask_q[18:0]))
    else $error("lines do not follow mask");
  a_strobe_hold: assert property (@(posedge clk)
    disable iff (!rst_n) stb_s && !stb_fall |=> shift_q == $past(shift_q))
    else $error("shift moved while strobe high");
  a_strobe_clear: assert property (@(posedge clk)
    disable iff (!rst_n) stb_fall |=> shift_q == WORD_RESET)
    else $error("shift not cleared");
  a_shift_in: assert property (@(posedge clk)
    disable iff (!rst_n) !stb_s && !stb_fall && sclk_fall |=>
    shift_q == {$past(shift_q[22:0]), $past(din_s)})
    else $error("bad shift");
  a_soft_limit: assert property (@(posedge clk)
    disable iff (!rst_n) ss_q == SS_RUN && !cfg_q.soft_start_disable |=>
    limit_q == LIMIT_SOFT)
    else $error("soft limit not held");
  a_soft_start_disable_limit: assert property (@(posedge clk)
    disable iff (!rst_n) cfg_q.soft_start_disable |=>
    limit_q == $past(cfg_q.current_limit_code))
    else $error("selected limit not applied");
  a_soft_restart: assert property (@(posedge clk)
    disable iff (!rst_n) start_evt |=> cnt_q == '0 &&
    (ss_q == SS_RUN) != $past(cfg_q.soft_start_disable))
    else $error("soft start not restarted");
  a_discharge_on: assert property (@(posedge clk)
    disable iff (!rst_n) lowered && enabled && HAS_BOOST |=> dis_q)
    else $error("discharge not started");
  a_raise_off: assert property (@(posedge clk)
    disable iff (!rst_n) raised |=> !dis_q)
    else $error("discharge on after raise");
  a_switch_idle: assert property (@(posedge clk)
    disable iff (!rst_n) !osc_s || !enabled |=> !gate_q)
    else $error("switch on without pwm");

endmodule : hv_output_boost_control

/* File: include/hv_boost_pkg.sv */
// constants and carrier types for the high-voltage output boost control
//
// Behaviour
// - word bit 0 picks destination: 0 loads configuration, 1 loads mask
// - mask bits 21..1 give one flag per line; set drives high
// - mask bits 23 and 22 do nothing and read as zero
// - power-on reset clears every implemented mask bit
// - lines 19 and 20 only work on the variant without boost
// - three-bit level code in configuration picks boost target voltage
// - two-bit limit code in configuration picks maximum boost current
// - switching input gates the switch, regulated by level and limit
// - host may send new level and limit codes at any time
// - after boost enable, hold lowest limit for 16384 switching cycles
// - when soft-start count expires, apply the selected limit code
// - soft-start disable flag set applies selected limit at once
// - lowering level while active turns discharge on until target
// - raising the level leaves discharge off
// - data shifts in msb first on falling serial clock edges
// - rising strobe edge copies shift register into selected latch
// - strobe high ignores clocks; strobe falling clears shift register
// - output gate low forces all lines low, high follows mask
package hv_boost_pkg;

  // ----------------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int SEL_BIT = 0;
  localparam int MASK_LSB = 1;
  localparam int LINES = 21;
  localparam int LEVEL_LSB = 1;
  localparam int LIMIT_LSB = 4;
  localparam int SOFT_OFF_BIT = 6;
  localparam int SYNC_BIT = 7;
  localparam int LIMIT_OFF_BIT = 8;

  // ----------------------------------------------------------------------
  // codes, counts and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [1:0] LIMIT_SOFT = 2'h0;
  localparam int SOFT_START_OSC_CYCLES = 16384;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [LINES-1:0] MASK_RESET = 21'h000000;

  // configuration latch contents
  typedef struct packed {
    logic limit_disable;
    logic sync_release;
    logic soft_start_disable;
    logic [1:0] current_limit_code;
    logic [2:0] boost_level_code;
  } cfg_s;

  localparam cfg_s CFG_RESET = '0;

endpackage : hv_boost_pkg

/* File: verification/hv_host_model.sv */
// host-side model: serial word loader and switching waveform source
`timescale 1ns/10ps
module hv_host_model #(
  parameter int HALF_BIT = 20,
  parameter int PWM_PER = 8,
  parameter int PWM_HIGH = 6
) (
  input wire logic clk,
  input wire logic pwm_en,
  output logic sclk,
  output logic sdin,
  output logic latch_strobe,
  output logic switch_drive_input
);
  int pcnt = 0;

  // idle levels: clock low, strobe high as after host setup
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    latch_strobe = 1'b1;
    switch_drive_input = 1'b0;
  end

  // --------------------------------------------------------------------
  // switching source
  // --------------------------------------------------------------------
  // duty inside band
  // six of eight cycles high, so the duty stays at 75 percent
  always @(posedge clk) begin
    pcnt <= (pcnt + 1) % PWM_PER;
    switch_drive_input <= pwm_en && (pcnt < PWM_HIGH);
  end

  // --------------------------------------------------------------------
  // serial frames
  // --------------------------------------------------------------------
  // msb first framing
  // strobe rise latches
  // data moves while the clock is high and once more as the strobe rises; the clock halts between frames
  task automatic send_frame(input int n, input logic [23:0] w);
    @(posedge clk);
    latch_strobe <= 1'b0;
    repeat (HALF_BIT) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      sdin <= w[i];
      repeat (HALF_BIT - 2) @(posedge clk);
      sclk <= 1'b0;
      repeat (HALF_BIT) @(posedge clk);
    end
    // released data line shows the inverse, not a stale bit
    sdin <= ~sdin;
    latch_strobe <= 1'b1;
    repeat (HALF_BIT) @(posedge clk);
  endtask : send_frame
endmodule : hv_host_model

/* File: verification/hv_output_boost_control_bench.sv */
// self-checking bench for the high-voltage output boost control
`timescale 1ns/10ps
module hv_output_boost_control_bench;
  import hv_boost_pkg::*;
  // soft start shortened so the run stays brief
  localparam int SOFT = 8;
  localparam logic [20:0] BOOST_DEAD = 21'h180000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic out_gate = 1'b0;
  logic rail_at_target = 1'b0;
  logic current_at_limit = 1'b0;
  logic pwm_en = 1'b0;
  logic sclk;
  logic sdin;
  logic latch_strobe;
  logic switch_drive_input;
  logic [LINES-1:0] hv_lines;
  logic [WORD_W-1:0] mask_word;
  cfg_s cfg_word;
  cfg_s c;
  logic [1:0] active_limit_code;
  logic switch_gate;
  logic discharge_en;
  logic soft_start_active;
  logic [WORD_W-1:0] w;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h71c2;
  int hits;

  always #2 clk = ~clk;

  hv_output_boost_control #(.SOFT_CYCLES(SOFT)) i_dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .sdin(sdin),
    .latch_strobe(latch_strobe), .out_gate(out_gate),
    .switch_drive_input(switch_drive_input),
    .rail_at_target(rail_at_target), .current_at_limit(current_at_limit),
    .hv_lines(hv_lines), .mask_word(mask_word), .cfg_word(cfg_word),
    .active_limit_code(active_limit_code), .switch_gate(switch_gate),
    .discharge_en(discharge_en), .soft_start_active(soft_start_active));

  hv_host_model i_host (
    .clk(clk), .pwm_en(pwm_en), .sclk(sclk), .sdin(sdin),
    .latch_strobe(latch_strobe), .switch_drive_input(switch_drive_input));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [WORD_W-1:0] cfg_frame(input cfg_s v);
    return {15'h0000, v, 1'b0};
  endfunction : cfg_frame

  // lines 19 and 20 stay dead on the boost variant
  function automatic logic [20:0] exp_lines(input logic [20:0] m,
                                            input logic g);
    return g ? (m & ~BOOST_DEAD) : 21'h000000;
  endfunction : exp_lines

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input int n, input logic [WORD_W-1:0] v);
    i_host.send_frame(n, v);
    repeat (8) @(posedge clk);
  endtask : send

  task automatic set_level(input logic [2:0] lv, input logic dis);
    c.boost_level_code = lv;
    send(24, cfg_frame(c));
    check(24'(discharge_en), 24'(dis));
  endtask : set_level

  task automatic count_gate(output int n);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      if (switch_gate === 1'b1) n++;
    end
  endtask : count_gate

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard: a full run needs roughly 13000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    c = '0;
    repeat (3) @(posedge clk);
    check(mask_word, 24'h000000);
    check(24'(hv_lines), 24'h000000);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    out_gate <= 1'b1;
    repeat (10) @(posedge clk);
    check(mask_word, 24'h000001);
    // all-ones corner first, then random masks with junk in the top bits
    for (int k = 0; k < 5; k++) begin
      w = (k == 0) ? 24'hFFFFFF : 24'($random(seed));
      w[0] = 1'b1;
      send(24, w);
      check(mask_word, {2'b00, w[21:1], 1'b1});
      check(24'(hv_lines), 24'(exp_lines(w[21:1], 1'b1)));
      check(24'(cfg_word), 24'h000000);
    end
    out_gate <= 1'b0;
    repeat (8) @(posedge clk);
    check(24'(hv_lines), 24'h000000);
    out_gate <= 1'b1;
    repeat (8) @(posedge clk);
    check(24'(hv_lines), 24'(exp_lines(w[21:1], 1'b1)));
    // short frame: stale bits would show if the strobe fall did not clear
    send(8, 24'h0000A5);
    check(mask_word, {2'b00, 21'h000052, 1'b1});
    c.current_limit_code = 2'h3;
    c.boost_level_code = 3'h4;
    send(24, cfg_frame(c));
    check(24'(cfg_word), 24'(c));
    check(mask_word, {2'b00, 21'h000052, 1'b1});
    check(24'(soft_start_active), 24'h000001);
    check(24'(active_limit_code), 24'(LIMIT_SOFT));
    pwm_en <= 1'b1;
    repeat (40) @(posedge clk);
    check(24'(soft_start_active), 24'h000001);
    for (int i = 0; i < 300 && soft_start_active !== 1'b0; i++) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    check(24'(soft_start_active), 24'h000000);
    check(24'(active_limit_code), 24'h000003);
    set_level(3'h3, 1'b1);
    set_level(3'h7, 1'b0);
    set_level(3'h5, 1'b1);
    rail_at_target <= 1'b1;
    repeat (8) @(posedge clk);
    check(24'(discharge_en), 24'h000000);
    rail_at_target <= 1'b0;
    repeat (8) @(posedge clk);
    count_gate(hits);
    // pwm stands high six cycles of eight, so 48 of 64 gate cycles
    check(24'(hits), 24'h000030);
    current_at_limit <= 1'b1;
    repeat (8) @(posedge clk);
    count_gate(hits);
    check(24'(hits), 24'h000000);
    // limit comparator ignored once limiting is switched off
    c.limit_disable = 1'b1;
    c.sync_release = 1'b1;
    send(24, cfg_frame(c));
    count_gate(hits);
    check(24'(hits), 24'h000030);
    // synchronised release: stop still latches at the next pwm rise
    rail_at_target <= 1'b1;
    repeat (16) @(posedge clk);
    count_gate(hits);
    check(24'(hits), 24'h000000);
    rail_at_target <= 1'b0;
    current_at_limit <= 1'b0;
    c.limit_disable = 1'b0;
    c.sync_release = 1'b0;
    set_level(3'h0, 1'b0);
    count_gate(hits);
    check(24'(hits), 24'h000000);
    c.soft_start_disable = 1'b1;
    c.current_limit_code = 2'h2;
    c.boost_level_code = 3'h2;
    send(24, cfg_frame(c));
    check(24'(active_limit_code), 24'h000002);
    check(24'(soft_start_active), 24'h000000);
    tally_and_finish();
  end
endmodule : hv_output_boost_control_bench
